// ==== include/qhdp_pkg.sv ====
// constants and carrier types for the buffer chain host data port
`default_nettype none
package qhdp_pkg;
    // register offsets on the host port
    localparam logic [9:0] OFS_SIZE = 10'h004;
    localparam logic [9:0] OFS_SETUP = 10'h008;
    localparam logic [9:0] OFS_TXD = 10'h00c;
    localparam logic [9:0] OFS_RXD = 10'h010;
    localparam logic [9:0] OFS_PTRS = 10'h018;
    localparam logic [9:0] OFS_RXSTAT = 10'h104;
    // field widths and positions
    localparam int SIZE_W = 16;
    localparam int CNT_W = 14;
    localparam int PTR_W = 7;
    localparam int SKIP_W = 2;
    localparam int ENDIAN_BIT = 24;
    localparam int START_LO = 18;
    localparam int END_LO = 16;
    localparam int CNT_LO = 0;
    localparam int LAST_LO = 16;
    localparam int FIRST_LO = 0;
    localparam int DONE_BIT = 31;
    localparam int WORD_LANES = 4;
    localparam logic [2:0] WORD_BYTES = 3'h4;
    // reset values
    localparam logic [SIZE_W-1:0] SIZE_RST = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_RST = 14'h0000;
    localparam logic [SKIP_W-1:0] SKIP_RST = 2'h0;
    localparam logic [PTR_W-1:0] PTR_RST = 7'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    // chains whose pointers reset to a non-zero block
    localparam int STATIC_CHAIN_A = 2;
    localparam int STATIC_CHAIN_B = 5;

    // one host access
    typedef struct packed {
        logic wr;
        logic [9:0] addr;
        logic [31:0] wdata;
    } qhdp_req_t;

    // one word bound for the chain with its byte lanes to keep
    typedef struct packed {
        logic [31:0] data;
        logic [WORD_LANES-1:0] keep;
    } qhdp_word_t;
endpackage
`default_nettype wire

// ==== core/qhdp_skid.sv ====
// two-entry buffer between the host port and the chain
`timescale 1ns/10ps
`default_nettype none
module qhdp_skid (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire qhdp_pkg::qhdp_word_t in_word,
    output logic out_valid,
    input wire logic out_ready,
    output qhdp_pkg::qhdp_word_t out_word
);
    qhdp_pkg::qhdp_word_t slot0_ff, slot1_ff, nxt_slot0, nxt_slot1;
    logic vld0_ff, vld1_ff, rdy_ff, nxt_vld0, nxt_vld1, nxt_rdy;
    logic push, pop;

    // head always sits in slot0 so the outputs come straight from flops
    always_comb begin
        push = in_valid && rdy_ff;
        pop = vld0_ff && out_ready;
        nxt_slot0 = slot0_ff;
        nxt_slot1 = slot1_ff;
        nxt_vld0 = vld0_ff;
        nxt_vld1 = vld1_ff;
        if (pop) begin
            nxt_slot0 = slot1_ff;
            nxt_vld0 = vld1_ff;
            nxt_vld1 = 1'b0;
        end
        if (push) begin
            if (!nxt_vld0) begin
                nxt_slot0 = in_word;
                nxt_vld0 = 1'b1;
            end else begin
                nxt_slot1 = in_word;
                nxt_vld1 = 1'b1;
            end
        end
        // ready is registered, so a full buffer refuses the very next push
        nxt_rdy = !nxt_vld1;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            slot0_ff <= '0;
            slot1_ff <= '0;
            vld0_ff <= 1'b0;
            vld1_ff <= 1'b0;
            rdy_ff <= 1'b1;
        end else begin
            slot0_ff <= nxt_slot0;
            slot1_ff <= nxt_slot1;
            vld0_ff <= nxt_vld0;
            vld1_ff <= nxt_vld1;
            rdy_ff <= nxt_rdy;
        end
    end

    assign in_ready = rdy_ff;
    assign out_valid = vld0_ff;
    assign out_word = slot0_ff;
endmodule // qhdp_skid
`default_nettype wire

// ==== core/qhdp_port.sv ====
// host data port of one buffer chain: setup, data in/out, block pointers
// Summary of operation
// - packet byte size held in 16 bits
// - setup bit picks msb-first or lsb-first order
// - start skip masks while countdown non-zero, self-clears
// - end skip masks at countdown zero, stays set
// - remaining size below four decides kept bytes
// - countdown drops per data write, holds zero
// - data port write appends masked word
// - receive port read returns and removes word
// - first and last pointers readable and writable
// - static chains two and five reset non-zero pointers
// - completion bit zero during ingress, one after
`timescale 1ns/10ps
`default_nettype none
module qhdp_port #(
    parameter int CHAIN_ID = 0,
    parameter logic [6:0] STATIC_FIRST = 7'h01,
    parameter logic [6:0] STATIC_LAST = 7'h01
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic req_valid,
    output logic req_ready,
    input wire qhdp_pkg::qhdp_req_t req,
    output logic rsp_valid,
    output logic [31:0] rsp_data,
    output logic tx_valid,
    input wire logic tx_ready,
    output qhdp_pkg::qhdp_word_t tx_word,
    output logic tx_msb_first,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [31:0] rx_data,
    input wire logic rx_done,
    output logic [6:0] first_ptr,
    output logic [6:0] last_ptr
);
    localparam bit IS_STATIC = (CHAIN_ID == qhdp_pkg::STATIC_CHAIN_A) ||
                               (CHAIN_ID == qhdp_pkg::STATIC_CHAIN_B);
    localparam logic [6:0] FIRST_RST = IS_STATIC ? STATIC_FIRST
                                                 : qhdp_pkg::PTR_RST;
    localparam logic [6:0] LAST_RST = IS_STATIC ? STATIC_LAST
                                                : qhdp_pkg::PTR_RST;

    logic [15:0] size_ff, nxt_size;
    logic [13:0] count_ff, nxt_count;
    logic [1:0] start_ff, nxt_start, end_ff, nxt_end;
    logic endian_ff, nxt_endian;
    logic [6:0] first_ff, nxt_first, last_ff, nxt_last;
    logic rsp_valid_ff, nxt_rsp_valid, rx_ready_ff, nxt_rx_ready;
    logic req_ready_ff, nxt_req_ready;
    logic [31:0] rsp_data_ff, nxt_rsp_data;
    logic acc, wr_txd, rd_rxd, buf_in_ready;
    logic [2:0] s_eff, e_eff, kept;
    qhdp_pkg::qhdp_word_t push_word;

    // lanes kept in transmit order: drop the first few and the last few
    function automatic logic [3:0] keep_mask(input logic msb,
                                             input logic [2:0] skip_first,
                                             input logic [2:0] skip_last);
        logic [3:0] m;
        m = '0;
        for (int p = 0; p < qhdp_pkg::WORD_LANES; p++) begin
            if (p >= int'(skip_first) &&
                p < qhdp_pkg::WORD_LANES - int'(skip_last)) begin
                m[msb ? qhdp_pkg::WORD_LANES - 1 - p : p] = 1'b1;
            end
        end
        return m;
    endfunction

    // masking of one data word
    always_comb begin
        acc = req_valid && req_ready_ff;
        wr_txd = acc && req.wr && (req.addr == qhdp_pkg::OFS_TXD);
        rd_rxd = acc && !req.wr && (req.addr == qhdp_pkg::OFS_RXD);
        s_eff = (count_ff != qhdp_pkg::CNT_RST) ? {1'b0, start_ff}
                                                : 3'h0;
        if (size_ff < 16'(qhdp_pkg::WORD_BYTES)) begin
            e_eff = qhdp_pkg::WORD_BYTES - size_ff[2:0];
        end else if (count_ff == qhdp_pkg::CNT_RST) begin
            e_eff = {1'b0, end_ff};
        end else begin
            e_eff = 3'h0;
        end
        push_word.data = req.wdata;
        push_word.keep = keep_mask(endian_ff, s_eff, e_eff);
        kept = 3'($countones(push_word.keep));
    end

    // register writes, countdown and read answers
    always_comb begin
        nxt_size = size_ff;
        nxt_count = count_ff;
        nxt_start = start_ff;
        nxt_end = end_ff;
        nxt_endian = endian_ff;
        nxt_first = first_ff;
        nxt_last = last_ff;
        if (acc && req.wr) begin
            if (req.addr == qhdp_pkg::OFS_SIZE) begin
                nxt_size = req.wdata[qhdp_pkg::SIZE_W-1:0];
            end else if (req.addr == qhdp_pkg::OFS_SETUP) begin
                nxt_endian = req.wdata[qhdp_pkg::ENDIAN_BIT];
                nxt_start = req.wdata[qhdp_pkg::START_LO +: qhdp_pkg::SKIP_W];
                nxt_end = req.wdata[qhdp_pkg::END_LO +: qhdp_pkg::SKIP_W];
                nxt_count = req.wdata[qhdp_pkg::CNT_LO +: qhdp_pkg::CNT_W];
            end else if (req.addr == qhdp_pkg::OFS_PTRS) begin
                nxt_last = req.wdata[qhdp_pkg::LAST_LO +: qhdp_pkg::PTR_W];
                nxt_first = req.wdata[qhdp_pkg::FIRST_LO +: qhdp_pkg::PTR_W];
            end else if (wr_txd) begin
                // the remainder never wraps, so late writes keep nothing
                nxt_size = (size_ff > 16'(kept)) ? size_ff - 16'(kept)
                                                 : qhdp_pkg::SIZE_RST;
                if (count_ff != qhdp_pkg::CNT_RST) begin
                    nxt_count = count_ff - 14'h0001;
                    nxt_start = qhdp_pkg::SKIP_RST;
                end
            end
        end
        nxt_rsp_valid = acc && !req.wr;
        nxt_rsp_data = qhdp_pkg::WORD_ZERO;
        if (req.addr == qhdp_pkg::OFS_SIZE) begin
            nxt_rsp_data = 32'(size_ff);
        end else if (req.addr == qhdp_pkg::OFS_SETUP) begin
            nxt_rsp_data[qhdp_pkg::ENDIAN_BIT] = endian_ff;
            nxt_rsp_data[qhdp_pkg::START_LO +: qhdp_pkg::SKIP_W] = start_ff;
            nxt_rsp_data[qhdp_pkg::END_LO +: qhdp_pkg::SKIP_W] = end_ff;
            nxt_rsp_data[qhdp_pkg::CNT_LO +: qhdp_pkg::CNT_W] = count_ff;
        end else if (req.addr == qhdp_pkg::OFS_RXD) begin
            nxt_rsp_data = rx_valid ? rx_data : qhdp_pkg::WORD_ZERO;
        end else if (req.addr == qhdp_pkg::OFS_PTRS) begin
            nxt_rsp_data[qhdp_pkg::LAST_LO +: qhdp_pkg::PTR_W] = last_ff;
            nxt_rsp_data[qhdp_pkg::FIRST_LO +: qhdp_pkg::PTR_W] = first_ff;
        end else if (req.addr == qhdp_pkg::OFS_RXSTAT) begin
            nxt_rsp_data[qhdp_pkg::DONE_BIT] = rx_done;
        end
        // the chain drops its head one cycle after the word was sampled
        nxt_rx_ready = rd_rxd && rx_valid;
        // one idle cycle after each access lets buffer fullness settle
        nxt_req_ready = !acc && buf_in_ready;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            size_ff <= qhdp_pkg::SIZE_RST;
            count_ff <= qhdp_pkg::CNT_RST;
            start_ff <= qhdp_pkg::SKIP_RST;
            end_ff <= qhdp_pkg::SKIP_RST;
            endian_ff <= 1'b0;
            first_ff <= FIRST_RST;
            last_ff <= LAST_RST;
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= qhdp_pkg::WORD_ZERO;
            rx_ready_ff <= 1'b0;
            req_ready_ff <= 1'b0;
        end else begin
            size_ff <= nxt_size;
            count_ff <= nxt_count;
            start_ff <= nxt_start;
            end_ff <= nxt_end;
            endian_ff <= nxt_endian;
            first_ff <= nxt_first;
            last_ff <= nxt_last;
            rsp_valid_ff <= nxt_rsp_valid;
            rsp_data_ff <= nxt_rsp_data;
            rx_ready_ff <= nxt_rx_ready;
            req_ready_ff <= nxt_req_ready;
        end
    end

    // a full buffer holds req_ready low, so no data word is lost
    qhdp_skid u_skid (
        .core_clk(core_clk),
        .rstn(rstn),
        .in_valid(wr_txd),
        .in_ready(buf_in_ready),
        .in_word(push_word),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_word(tx_word)
    );

    assign req_ready = req_ready_ff;
    assign rsp_valid = rsp_valid_ff;
    assign rsp_data = rsp_data_ff;
    assign rx_ready = rx_ready_ff;
    assign tx_msb_first = endian_ff;
    assign first_ptr = first_ff;
    assign last_ptr = last_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    property p_size_wr;
        acc && req.wr && req.addr == qhdp_pkg::OFS_SIZE |=>
            size_ff == $past(req.wdata[qhdp_pkg::SIZE_W-1:0]);
    endproperty
    a_size_wr: assert property (p_size_wr)
        else $error("size write not stored");

    property p_order;
        acc && req.wr && req.addr == qhdp_pkg::OFS_SETUP |=>
            tx_msb_first == $past(req.wdata[qhdp_pkg::ENDIAN_BIT]);
    endproperty
    a_order: assert property (p_order)
        else $error("byte order not taken from setup");

    property p_start_clear;
        wr_txd && count_ff != 14'h0000 |=> start_ff == 2'h0;
    endproperty
    a_start_clear: assert property (p_start_clear)
        else $error("start skip did not clear");

    property p_end_hold;
        wr_txd && count_ff == 14'h0000 |=> end_ff == $past(end_ff);
    endproperty
    a_end_hold: assert property (p_end_hold)
        else $error("end skip changed on data write");

    property p_short_tail;
        wr_txd && size_ff < 16'h0004 |-> 16'(kept) <= size_ff;
    endproperty
    a_short_tail: assert property (p_short_tail)
        else $error("kept bytes exceed remaining size");

    property p_countdown;
        wr_txd |=> count_ff == (($past(count_ff) == 14'h0000) ? 14'h0000
                                : $past(count_ff) - 14'h0001);
    endproperty
    a_countdown: assert property (p_countdown)
        else $error("countdown step wrong");

    property p_append;
        wr_txd |-> buf_in_ready ##1 tx_valid;
    endproperty
    a_append: assert property (p_append)
        else $error("data word not appended");

    property p_rx_pop;
        rd_rxd && rx_valid |=> rx_ready && rsp_valid &&
            rsp_data == $past(rx_data) ##1 !rx_ready;
    endproperty
    a_rx_pop: assert property (p_rx_pop)
        else $error("receive read did not pop once");

    property p_ptrs;
        acc && req.wr && req.addr == qhdp_pkg::OFS_PTRS |=>
            first_ptr ==
                $past(req.wdata[qhdp_pkg::FIRST_LO +: qhdp_pkg::PTR_W]) &&
            last_ptr ==
                $past(req.wdata[qhdp_pkg::LAST_LO +: qhdp_pkg::PTR_W]);
    endproperty
    a_ptrs: assert property (p_ptrs)
        else $error("pointer write not stored");

    property p_done;
        acc && !req.wr && req.addr == qhdp_pkg::OFS_RXSTAT |=>
            rsp_data[qhdp_pkg::DONE_BIT] == $past(rx_done);
    endproperty
    a_done: assert property (p_done)
        else $error("completion bit wrong");

    property p_lane;
        wr_txd && count_ff != 14'h0000 && start_ff != 2'h0 |->
            (endian_ff ? !push_word.keep[3] : !push_word.keep[0]);
    endproperty
    a_lane: assert property (p_lane)
        else $error("start skip hit wrong lane");
endmodule // qhdp_port
`default_nettype wire

// ==== verification/qhdp_chain_model.sv ====
// chain-side model: sink for transmit words, source of receive words
`timescale 1ns/10ps
`default_nettype none
module qhdp_chain_model #(
    parameter int RX_WORDS = 3
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic stall,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire qhdp_pkg::qhdp_word_t tx_word,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [31:0] rx_data
);
    qhdp_pkg::qhdp_word_t got[$];
    int idx = 0;
    int cyc = 0;
    // stall keeps the head word waiting inside the device buffer
    assign tx_ready = ~stall;
    assign rx_valid = idx < RX_WORDS;
    // an empty chain shows a changing pattern, so stale data cannot pass
    assign rx_data = rx_valid ? 32'hc0de_0000 + 32'(idx) : ~32'(cyc);
    // capture pushed words and pop the head on each pulse
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (!rstn) begin
            idx <= 0;
        end else begin
            if (tx_valid && tx_ready) begin
                got.push_back(tx_word);
            end
            if (rx_ready && rx_valid) begin
                idx <= idx + 1;
            end
        end
    end
endmodule // qhdp_chain_model
`default_nettype wire

// ==== verification/testbench.sv ====
// self-checking bench for the buffer chain host data port
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic req_valid = 1'b0;
    qhdp_pkg::qhdp_req_t req = '0;
    logic stall = 1'b0;
    logic rx_done = 1'b0;
    logic req_ready, rsp_valid, tx_valid, tx_ready, tx_msb_first;
    logic rx_valid, rx_ready;
    logic [31:0] rsp_data, rx_data, rd;
    logic [6:0] first_ptr, last_ptr;
    qhdp_pkg::qhdp_word_t tx_word;
    int n_mismatch = 0;
    int checked = 0;

    qhdp_port #(.CHAIN_ID(2), .STATIC_FIRST(7'h0a), .STATIC_LAST(7'h15)) dut (
        .core_clk(core_clk), .rstn(rstn), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_word(tx_word), .tx_msb_first(tx_msb_first),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
        .rx_done(rx_done), .first_ptr(first_ptr), .last_ptr(last_ptr));

    qhdp_chain_model #(.RX_WORDS(3)) chain (
        .core_clk(core_clk), .rstn(rstn), .stall(stall),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_word(tx_word),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));

    always #50 core_clk = ~core_clk;

    task automatic chk(input string what, input logic [35:0] exp,
                       input logic [35:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one host access; held until taken, read data caught the cycle after
    task automatic access(input logic wr, input logic [9:0] addr,
                          input logic [31:0] wdata);
        int n;
        n = 0;
        req_valid = 1'b1;
        req = '{wr, addr, wdata};
        @(posedge core_clk);
        while (req_ready !== 1'b1 && n < 50) begin
            n++;
            @(posedge core_clk);
        end
        #1;
        req_valid = 1'b0;
        chk("req_taken", 36'h1, 36'(n < 50));
        if (!wr) begin
            chk("rsp_valid", 36'h1, 36'(rsp_valid));
            rd = rsp_data;
        end
        @(posedge core_clk);
        #1;
    endtask

    task automatic rd_chk(input string what, input logic [9:0] addr,
                          input logic [31:0] exp);
        access(1'b0, addr, 32'h0);
        chk(what, 36'(exp), 36'(rd));
    endtask

    // waits, bounded, for the chain to receive the next word
    task automatic chk_tx(input logic [35:0] exp);
        int n;
        n = 0;
        while (chain.got.size() == 0 && n < 20) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("tx_word", exp, chain.got.pop_front());
    endtask

    task automatic t_reset();
        chk("first_ptr", 36'h0a, 36'(first_ptr));
        chk("last_ptr", 36'h15, 36'(last_ptr));
        rd_chk("ptrs", qhdp_pkg::OFS_PTRS, 32'h0015_000a);
        rd_chk("size", qhdp_pkg::OFS_SIZE, 32'h0);
        rd_chk("setup", qhdp_pkg::OFS_SETUP, 32'h0);
    endtask

    task automatic t_regs();
        access(1'b1, qhdp_pkg::OFS_SIZE, 32'hffff_1234);
        rd_chk("size", qhdp_pkg::OFS_SIZE, 32'h0000_1234);
        access(1'b1, qhdp_pkg::OFS_PTRS, 32'hffff_ffff);
        rd_chk("ptrs", qhdp_pkg::OFS_PTRS, 32'h007f_007f);
        access(1'b1, qhdp_pkg::OFS_PTRS, 32'h0033_0044);
        chk("ptr_pins", 36'h3344,
            36'({1'b0, last_ptr, 1'b0, first_ptr}));
        rd_chk("unmapped", 10'h020, 32'h0);
        rd_chk("txd_read", qhdp_pkg::OFS_TXD, 32'h0);
    endtask

    // lsb first, start skip 1, end skip 2 overridden by a 3-byte remainder
    task automatic t_tx_lsb();
        access(1'b1, qhdp_pkg::OFS_SIZE, 32'd10);
        access(1'b1, qhdp_pkg::OFS_SETUP, 32'h0006_0002);
        chk("msb_first", 36'h0, 36'(tx_msb_first));
        stall = 1'b1;
        access(1'b1, qhdp_pkg::OFS_TXD, 32'h4433_2211);
        access(1'b1, qhdp_pkg::OFS_TXD, 32'h8877_6655);
        repeat (3) @(posedge core_clk);
        #1;
        chk("buf_full", 36'h2, 36'({tx_valid, req_ready}));
        stall = 1'b0;
        access(1'b1, qhdp_pkg::OFS_TXD, 32'hccbb_aa99);
        chk_tx({32'h4433_2211, 4'he});
        chk_tx({32'h8877_6655, 4'hf});
        chk_tx({32'hccbb_aa99, 4'h7});
        rd_chk("setup", qhdp_pkg::OFS_SETUP, 32'h0002_0000);
        rd_chk("size", qhdp_pkg::OFS_SIZE, 32'h0);
    endtask

    // msb first, start skip 2, end skip 1 kept on every write after zero
    task automatic t_tx_msb();
        access(1'b1, qhdp_pkg::OFS_SIZE, 32'h0000_0100);
        // count 1 for three writes, so the end skip stays on past zero
        access(1'b1, qhdp_pkg::OFS_SETUP, 32'h0109_0001);
        chk("msb_first", 36'h1, 36'(tx_msb_first));
        access(1'b1, qhdp_pkg::OFS_TXD, 32'h0403_0201);
        access(1'b1, qhdp_pkg::OFS_TXD, 32'h0807_0605);
        access(1'b1, qhdp_pkg::OFS_TXD, 32'h0c0b_0a09);
        chk_tx({32'h0403_0201, 4'h3});
        chk_tx({32'h0807_0605, 4'he});
        chk_tx({32'h0c0b_0a09, 4'he});
        rd_chk("setup", qhdp_pkg::OFS_SETUP, 32'h0101_0000);
        rd_chk("size", qhdp_pkg::OFS_SIZE, 32'h0000_00f8);
    endtask

    task automatic t_rx();
        rd_chk("done", qhdp_pkg::OFS_RXSTAT, 32'h0);
        rd_chk("rx0", qhdp_pkg::OFS_RXD, 32'hc0de_0000);
        rd_chk("rx1", qhdp_pkg::OFS_RXD, 32'hc0de_0001);
        rx_done = 1'b1;
        rd_chk("done", qhdp_pkg::OFS_RXSTAT, 32'h8000_0000);
        rd_chk("rx2", qhdp_pkg::OFS_RXD, 32'hc0de_0002);
        rd_chk("rx_empty", qhdp_pkg::OFS_RXD, 32'h0);
    endtask

    task automatic give_verdict();
        if (n_mismatch == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // hang guard, far beyond the hundred or so cycles the tests need
    initial begin
        #2_000_000;
        n_mismatch++;
        give_verdict();
    end

    initial begin
        repeat (5) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        t_reset();
        t_regs();
        t_tx_lsb();
        t_tx_msb();
        t_rx();
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
